// ===== hdl/sdcl_device.sv
// device end: divider holding registers, serial shifter, output and test model
// assumes pins arrive asynchronously; refIn is the selected reference as a level
`timescale 1ns/1ps
`default_nettype none
`include "sdcl_map.svh"
module sdcl_device (
  input  wire logic  clk,
  input  wire logic  rst_n,
  sdcl_pins_if.device pins,
  input  wire logic  refIn,
  output logic       synthOutput,
  output logic       testOutput
);

  // ========================================================
  // decoding helpers
  function automatic logic [3:0] divRatio(input logic [1:0] sel);
    case (sel)
      `SDCL_N_DIV1: divRatio = 4'h1;
      `SDCL_N_DIV2: divRatio = 4'h2;
      `SDCL_N_DIV4: divRatio = 4'h4;
      `SDCL_N_DIV8: divRatio = 4'h8;
      default:      divRatio = 4'h2;
    endcase
  endfunction

  function automatic logic testNode(
    input logic [2:0] sel,
    input logic       srOut,
    input logic       refLvl,
    input logic       loopOut,
    input logic       synth_output,
    input logic       mOut,
    input logic       fout4
  );
    case (sel)
      `SDCL_T_SHIFT:  testNode = srOut;
      `SDCL_T_HIGH:   testNode = 1'b1;
      `SDCL_T_REF:    testNode = refLvl;
      `SDCL_T_MCNT:   testNode = loopOut;
      `SDCL_T_SYNTH_OUTPUT:   testNode = synth_output;
      `SDCL_T_LOW:    testNode = 1'b0;
      `SDCL_T_BYPASS: testNode = mOut;
      `SDCL_T_FOUT4:  testNode = fout4;
      default:        testNode = 1'b0;
    endcase
  endfunction

  sdcl_pkg::sdcl_dev_s st;
  sdcl_pkg::sdcl_dev_s next_st;

  logic [`SDCL_PIN_W-1:0] pinsIn;
  assign pinsIn = {refIn, pins.serialLoad, pins.serialData, pins.serialClock,
                   pins.parallelStrobe, pins.outDivSel, pins.loopValue};

  // ========================================================
  // next state
  always_comb begin
    logic [`SDCL_PIN_W-1:0] agree;
    logic                   pRise;
    logic                   sclkRise;
    logic                   sldFall;
    logic                   refRise;
    logic                   bypass;
    logic [15:0]            acc;
    logic [15:0]            thr;
    logic [2:0]             half;
    logic                   mOut;
    agree    = '0;
    pRise    = 1'b0;
    sclkRise = 1'b0;
    sldFall  = 1'b0;
    refRise  = 1'b0;
    bypass   = 1'b0;
    acc      = '0;
    thr      = '0;
    half     = '0;
    mOut     = 1'b0;
    next_st  = st;

    // three-stage synchroniser, a change counts once stages two and three agree
    next_st.s1  = pinsIn;
    next_st.s2  = st.s1;
    next_st.s3  = st.s2;
    agree       = ~(st.s2 ^ st.s3);
    next_st.pin = (st.s3 & agree) | (st.pin & ~agree);

    pRise    = next_st.pin[`SDCL_PIN_PSTB] & ~st.pin[`SDCL_PIN_PSTB];
    sclkRise = next_st.pin[`SDCL_PIN_SCLK] & ~st.pin[`SDCL_PIN_SCLK];
    sldFall  = ~next_st.pin[`SDCL_PIN_SLD] & st.pin[`SDCL_PIN_SLD];
    refRise  = next_st.pin[`SDCL_PIN_REF] & ~st.pin[`SDCL_PIN_REF];

    // ------------------------------------------------------
    // serial shifter: shifting alone never touches the holding registers
    if (sclkRise) begin
      next_st.shiftReg = {st.shiftReg[`SDCL_SR_W-2:0],
                          next_st.pin[`SDCL_PIN_SDAT]};
    end

    // ------------------------------------------------------
    // holding registers, parallel path first
    if (!next_st.pin[`SDCL_PIN_PSTB]) begin
      next_st.loopVal = next_st.pin[`SDCL_PIN_M_HI:0];
      next_st.divSel  = next_st.pin[`SDCL_PIN_N_HI:`SDCL_PIN_N_LO];
      next_st.testSel = 3'h0;
    end else if (pRise) begin
      // last transparent value equals the value at the edge
      next_st.loopVal = st.pin[`SDCL_PIN_M_HI:0];
      next_st.divSel  = st.pin[`SDCL_PIN_N_HI:`SDCL_PIN_N_LO];
    end else if (sldFall) begin
      next_st.testSel = st.shiftReg[`SDCL_T_HI:`SDCL_T_LO];
      next_st.divSel  = st.shiftReg[`SDCL_N_HI:`SDCL_N_LO];
      next_st.loopVal = st.shiftReg[`SDCL_M_HI:0];
    end

    bypass = (st.testSel == `SDCL_T_BYPASS);

    // ------------------------------------------------------
    // loop model: one output half period per PREDIV/2*N reference edges per 2M
    // limitation: at most one output toggle per clk, so real rates saturate
    thr = 16'((`SDCL_REF_PREDIV / 2) * divRatio(st.divSel));
    acc = st.phaseAcc;
    if (!bypass && refRise) begin
      next_st.refDiv = st.refDiv + 4'h1;
      acc = st.phaseAcc + {6'h0, st.loopVal, 1'b0};
    end
    if (!bypass) begin
      next_st.mCnt = '0;
      next_st.nCnt = '0;
      if (acc >= thr) begin
        acc              = acc - thr;
        next_st.synthOut = ~st.synthOut;
      end
      next_st.phaseAcc = acc;
    end else begin
      // bypass: serial clock drives both dividers directly
      next_st.phaseAcc = '0;
      half = 3'(divRatio(st.divSel) >> 1);
      if (st.divSel == `SDCL_N_DIV1) begin
        next_st.synthOut = next_st.pin[`SDCL_PIN_SCLK];
      end else if (sclkRise) begin
        if (st.nCnt + 3'h1 >= half) begin
          next_st.nCnt     = 3'h0;
          next_st.synthOut = ~st.synthOut;
        end else begin
          next_st.nCnt = st.nCnt + 3'h1;
        end
      end
      if (sclkRise) begin
        if (st.mCnt + 9'h001 >= st.loopVal) begin
          next_st.mCnt = 9'h000;
        end else begin
          next_st.mCnt = st.mCnt + 9'h001;
        end
      end
    end
    mOut = (st.mCnt == 9'h000);

    if (next_st.synthOut & ~st.synthOut) begin
      next_st.quarter = st.quarter + 2'h1;
    end

    next_st.testOut = testNode(st.testSel,
                               st.shiftReg[`SDCL_SR_W-1],
                               st.pin[`SDCL_PIN_REF],
                               st.refDiv[3],
                               st.synthOut,
                               mOut,
                               st.quarter[1]);
  end

  // ========================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign synthOutput = st.synthOut;
  assign testOutput  = st.testOut;

endmodule
`default_nettype wire

// ===== hdl/sdcl_host.sv
// host end: AHB-Lite registers and the strobe sequencer driving the pins
// assumes a single AHB-Lite master, word transfers only
`timescale 1ns/1ps
`default_nettype none
`include "sdcl_map.svh"
module sdcl_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  sdcl_pins_if.host        pins
);

  sdcl_pkg::sdcl_host_s st;
  sdcl_pkg::sdcl_host_s next_st;

  always_comb begin
    logic addrPh;
    logic tick;
    logic busy;
    logic [8:0] mNew;
    addrPh  = 1'b0;
    tick    = 1'b0;
    busy    = 1'b0;
    mNew    = '0;
    next_st = st;
    busy    = (st.fsm != sdcl_pkg::SDCL_IDLE);

    // ======================================================
    // strobe phase divider, one enable pulse per half period
    if (busy) begin
      if (st.tickCnt == 4'(`SDCL_HALF_CYC - 1)) begin
        next_st.tickCnt = 4'h0;
        tick = 1'b1;
      end else begin
        next_st.tickCnt = st.tickCnt + 4'h1;
      end
    end else begin
      next_st.tickCnt = 4'h0;
    end

    // ======================================================
    // bus slave, zero wait states
    addrPh = hsel & htrans[1] & hready;
    next_st.wrPend = addrPh & hwrite;
    if (addrPh) begin
      next_st.wrAddr = haddr[7:0];
      case (haddr[7:0])
        `SDCL_REG_CONFIG: next_st.hrdata = {18'h0, st.cfg};
        `SDCL_REG_STATUS: next_st.hrdata = {30'h0, st.rejected, busy};
        default:          next_st.hrdata = 32'h0000_0000;
      endcase
    end

    // ======================================================
    // sequencer
    case (st.fsm)
      sdcl_pkg::SDCL_IDLE: begin
        if (st.wrPend && st.wrAddr == `SDCL_REG_CTRL) begin
          if (hwdata[0]) begin
            next_st.fsm       = sdcl_pkg::SDCL_PLOW;
            next_st.loopValue = st.cfg[`SDCL_M_HI:0];
            next_st.outDivSel = st.cfg[`SDCL_N_HI:`SDCL_N_LO];
            next_st.parallelStrobe = 1'b0;
          end else if (hwdata[1]) begin
            next_st.fsm    = sdcl_pkg::SDCL_SLO;
            next_st.txWord = st.cfg;
            next_st.bitCnt = 4'h0;
          end
        end
      end
      sdcl_pkg::SDCL_PLOW: begin
        if (tick) begin
          next_st.fsm = sdcl_pkg::SDCL_PHIGH;
          next_st.parallelStrobe = 1'b1;
        end
      end
      sdcl_pkg::SDCL_PHIGH: begin
        if (tick) begin
          next_st.fsm = sdcl_pkg::SDCL_IDLE;
        end
      end
      sdcl_pkg::SDCL_SLO: begin
        next_st.serialClock = 1'b0;
        next_st.serialData  = st.txWord[`SDCL_SR_W-1];
        if (tick) begin
          next_st.fsm = sdcl_pkg::SDCL_SHI;
          next_st.serialClock = 1'b1;
        end
      end
      sdcl_pkg::SDCL_SHI: begin
        if (tick) begin
          next_st.serialClock = 1'b0;
          next_st.txWord = {st.txWord[`SDCL_SR_W-2:0], 1'b0};
          next_st.bitCnt = st.bitCnt + 4'h1;
          if (st.bitCnt == 4'(`SDCL_SR_W - 1)) begin
            next_st.fsm = sdcl_pkg::SDCL_LDHI;
            next_st.serialLoad = 1'b1;
          end else begin
            next_st.fsm = sdcl_pkg::SDCL_SLO;
          end
        end
      end
      sdcl_pkg::SDCL_LDHI: begin
        if (tick) begin
          next_st.fsm = sdcl_pkg::SDCL_LDLO;
          next_st.serialLoad = 1'b0; // load strobe falls; device commits
        end
      end
      sdcl_pkg::SDCL_LDLO: begin
        if (tick) begin
          next_st.fsm = sdcl_pkg::SDCL_IDLE;
        end
      end
      default: begin
        next_st.fsm = sdcl_pkg::SDCL_IDLE;
      end
    endcase

    // configuration word; out-of-range loop values are refused
    if (st.wrPend && st.wrAddr == `SDCL_REG_CONFIG && !busy) begin
      mNew = hwdata[`SDCL_M_HI:0];
      if (mNew >= `SDCL_M_MIN && mNew <= `SDCL_M_MAX) begin
        next_st.cfg      = hwdata[`SDCL_SR_W-1:0];
        next_st.rejected = 1'b0;
      end else begin
        next_st.rejected = 1'b1;
      end
    end
  end

  // ========================================================
  // state register; reset starts the power-up parallel load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st                <= '0;
      st.fsm            <= sdcl_pkg::SDCL_PLOW;
      st.cfg            <= `SDCL_CFG_RESET;
      st.loopValue      <= `SDCL_M_MIN;
      st.hreadyout      <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata              = st.hrdata;
  assign hreadyout           = st.hreadyout;
  assign hresp               = 1'b0;
  assign pins.loopValue      = st.loopValue;
  assign pins.outDivSel      = st.outDivSel;
  assign pins.parallelStrobe = st.parallelStrobe;
  assign pins.serialClock    = st.serialClock;
  assign pins.serialData     = st.serialData;
  assign pins.serialLoad     = st.serialLoad;

endmodule
`default_nettype wire

// ===== hdl/sdcl_map.svh
// offsets, field positions, reset values and timing counts of the divider loader
// assumes inclusion by bare name from every design file of the block
`ifndef SDCL_MAP_SVH
`define SDCL_MAP_SVH

// ==========================================================
// pin vector seen by the device synchroniser
`define SDCL_PIN_W     16
`define SDCL_PIN_M_HI  8
`define SDCL_PIN_N_LO  9
`define SDCL_PIN_N_HI  10
`define SDCL_PIN_PSTB  11
`define SDCL_PIN_SCLK  12
`define SDCL_PIN_SDAT  13
`define SDCL_PIN_SLD   14
`define SDCL_PIN_REF   15

// ==========================================================
// serial word: test bits first, then output divider, then loop divider
`define SDCL_SR_W      14
`define SDCL_T_HI      13
`define SDCL_T_LO      11
`define SDCL_N_HI      10
`define SDCL_N_LO      9
`define SDCL_M_HI      8

// ==========================================================
// divider encodings and test codes
`define SDCL_N_DIV1    2'h3
`define SDCL_N_DIV2    2'h0
`define SDCL_N_DIV4    2'h1
`define SDCL_N_DIV8    2'h2
`define SDCL_REF_PREDIV 16
`define SDCL_M_MIN     9'h0C8
`define SDCL_M_MAX     9'h190
`define SDCL_T_SHIFT   3'h0
`define SDCL_T_HIGH    3'h1
`define SDCL_T_REF     3'h2
`define SDCL_T_MCNT    3'h3
`define SDCL_T_SYNTH_OUTPUT    3'h4
`define SDCL_T_LOW     3'h5
`define SDCL_T_BYPASS  3'h6
`define SDCL_T_FOUT4   3'h7

// ==========================================================
// host register map and reset values
`define SDCL_REG_CTRL   8'h00
`define SDCL_REG_CONFIG 8'h04
`define SDCL_REG_STATUS 8'h08
`define SDCL_CFG_RESET  14'h00C8

// ==========================================================
// strobe timing: half period of every host strobe phase
`define SDCL_CLK_NS    20
`define SDCL_HALF_NS   60
`define SDCL_HALF_CYC  ((`SDCL_HALF_NS + `SDCL_CLK_NS - 1) / `SDCL_CLK_NS)

`endif

// ===== hdl/sdcl_pins_if.sv
// configuration pins between the host end and the device end
// assumes both ends run on the same clk; the device still synchronises them
`timescale 1ns/1ps
`default_nettype none
interface sdcl_pins_if;
  logic [8:0] loopValue;
  logic [1:0] outDivSel;
  logic       parallelStrobe;
  logic       serialClock;
  logic       serialData;
  logic       serialLoad;

  modport host (
    output loopValue,
    output outDivSel,
    output parallelStrobe,
    output serialClock,
    output serialData,
    output serialLoad
  );

  modport device (
    input loopValue,
    input outDivSel,
    input parallelStrobe,
    input serialClock,
    input serialData,
    input serialLoad
  );
endinterface
`default_nettype wire

// ===== hdl/sdcl_pkg.sv
// types shared by both ends of the divider configuration loader
// assumes sdcl_map.svh constants; no logic of its own
`include "sdcl_map.svh"
package sdcl_pkg;

  // ========================================================
  // device state
  typedef struct packed {
    logic [`SDCL_PIN_W-1:0] s1;
    logic [`SDCL_PIN_W-1:0] s2;
    logic [`SDCL_PIN_W-1:0] s3;
    logic [`SDCL_PIN_W-1:0] pin;
    logic [`SDCL_SR_W-1:0]  shiftReg;
    logic [2:0]             testSel;
    logic [1:0]             divSel;
    logic [8:0]             loopVal;
    logic [15:0]            phaseAcc;
    logic [3:0]             refDiv;
    logic [8:0]             mCnt;
    logic [2:0]             nCnt;
    logic [1:0]             quarter;
    logic                   synthOut;
    logic                   testOut;
  } sdcl_dev_s;

  // ========================================================
  // host sequencer
  typedef enum logic [2:0] {
    SDCL_IDLE  = 3'b000,
    SDCL_PLOW  = 3'b001,
    SDCL_PHIGH = 3'b010,
    SDCL_SLO   = 3'b011,
    SDCL_SHI   = 3'b100,
    SDCL_LDHI  = 3'b101,
    SDCL_LDLO  = 3'b110
  } sdcl_host_e;

  typedef struct packed {
    sdcl_host_e             fsm;
    logic [3:0]             tickCnt;
    logic [3:0]             bitCnt;
    logic [`SDCL_SR_W-1:0]  cfg;
    logic [`SDCL_SR_W-1:0]  txWord;
    logic                   rejected;
    logic                   wrPend;
    logic [7:0]             wrAddr;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic [8:0]             loopValue;
    logic [1:0]             outDivSel;
    logic                   parallelStrobe;
    logic                   serialClock;
    logic                   serialData;
    logic                   serialLoad;
  } sdcl_host_s;

endpackage

// ===== verif/sdcl_link_props.sv
// assertions on the configuration pins between host end and device end
// assumes instantiation beside the pins interface, one clk domain
`timescale 1ns/1ps
`default_nettype none
module sdcl_link_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [8:0] loopValue,
  input wire logic [1:0] outDivSel,
  input wire logic       parallelStrobe,
  input wire logic       serialClock,
  input wire logic       serialData,
  input wire logic       serialLoad
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // serial clock rises since the last commit
  logic [4:0] bitCount;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bitCount <= 5'h00;
    end else if ($fell(serialLoad)) begin
      bitCount <= 5'h00;
    end else if ($rose(serialClock)) begin
      bitCount <= bitCount + 5'h01;
    end
  end

  // ==========================================================
  // phases of three cycles each
  sequence strobeLowPhase;
    !parallelStrobe[*3] ##1 parallelStrobe;
  endsequence
  sequence clockHighPhase;
    serialClock[*3] ##1 !serialClock;
  endsequence
  sequence loadPulse;
    serialLoad[*3] ##1 !serialLoad;
  endsequence

  strobe_low_a: assert property ($fell(parallelStrobe) |-> strobeLowPhase)
    else $error("parallel strobe low phase not three cycles");
  clock_high_a: assert property ($rose(serialClock) |-> clockHighPhase)
    else $error("serial clock high phase not three cycles");
  load_pulse_a: assert property ($rose(serialLoad) |-> loadPulse)
    else $error("load pulse not three cycles");
  serial_gate_a: assert property ((serialClock || serialLoad) |-> parallelStrobe)
    else $error("serial activity with parallel strobe low");
  data_hold_a: assert property (serialClock |-> $stable(serialData))
    else $error("serial data moved while serial clock high");
  load_count_a: assert property ($rose(serialLoad) |-> bitCount == 5'h0E)
    else $error("load pulse before fourteen bits");
  load_quiet_a: assert property (serialLoad |-> !serialClock)
    else $error("serial clock high during load pulse");
  capture_hold_a: assert property ($rose(parallelStrobe) |-> $stable({outDivSel, loopValue}))
    else $error("divider pins moved at parallel capture");
endmodule
`default_nettype wire

// ===== verif/sdcl_tb_top.sv
// self-checking bench: host end and device end joined by the pins interface
// assumes the design files and sdcl_map.svh compile first
`timescale 1ns/1ps
`default_nettype none
`include "sdcl_map.svh"
module sdcl_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        refIn = 1'b0;
  logic [5:0]  refCnt = 6'h00;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        synthOutput;
  logic        testOutput;
  int          miscompares = 0;
  int          checked = 0;
  int          toggles = 0;
  logic [32:0] rdQ[$];
  logic [13:0] serQ[$];
  logic [10:0] parQ[$];
  logic        rdPend = 1'b0;
  logic [13:0] shifted = 14'h0;
  logic [3:0]  prev = 4'h0;

  sdcl_pins_if pins ();
  sdcl_host sdcl_host_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .pins(pins));
  sdcl_device sdcl_device_inst (.clk(clk), .rst_n(rst_n), .pins(pins), .refIn(refIn),
    .synthOutput(synthOutput), .testOutput(testOutput));
  sdcl_link_props sdcl_link_props_inst (.clk(clk), .rst_n(rst_n), .loopValue(pins.loopValue),
    .outDivSel(pins.outDivSel), .parallelStrobe(pins.parallelStrobe),
    .serialClock(pins.serialClock), .serialData(pins.serialData), .serialLoad(pins.serialLoad));

  always #10 clk = ~clk;
  // reference period of 64 clk keeps every ratio of the ratio test (divide by 2, 4, 8) below the clk/2 ceiling
  always @(posedge clk) begin
    refCnt <= refCnt + 6'h01;
    refIn <= refCnt[5];
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] e);
    logic [31:0] r;
    rdQ.push_back({c, e});
    ahb(1'b0, a, 32'h0, r);
  endtask
  task automatic waitIdle;
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 100 && s[0] !== 1'b0; i++) begin
      rdQ.push_back(33'h0);
      ahb(1'b0, `SDCL_REG_STATUS, 32'h0, s);
    end
    // three sync stages, commit and output flop, with margin
    repeat (8) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("comparisons %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // result watcher: pops the oldest note as each result appears
  always @(posedge clk) begin
    logic [32:0] e;
    if (rdPend && rdQ.size() > 0) begin
      e = rdQ.pop_front();
      if (e[32]) chk(hrdata, e[31:0]);
      chk({31'h0, hresp}, 32'h0000_0000);
    end
    rdPend = rst_n && hsel && htrans[1] && !hwrite && hready;
    if (rst_n && pins.serialClock && !prev[0]) shifted = {shifted[12:0], pins.serialData};
    if (rst_n && !pins.serialLoad && prev[1] && serQ.size() > 0)
      chk({18'h0, shifted}, {18'h0, serQ.pop_front()});
    if (rst_n && pins.parallelStrobe && !prev[2] && parQ.size() > 0)
      chk({21'h0, pins.outDivSel, pins.loopValue}, {21'h0, parQ.pop_front()});
    if (synthOutput !== prev[3]) toggles++;
    prev = {synthOutput, pins.parallelStrobe, pins.serialLoad, pins.serialClock};
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    static logic [8:0] bad [2] = '{9'h0C7, 9'h191};
    static logic [2:0] tc [2] = '{`SDCL_T_LOW, `SDCL_T_HIGH};
    static logic [1:0] nc [3] = '{`SDCL_N_DIV2, `SDCL_N_DIV4, `SDCL_N_DIV8};
    static int         dv [3] = '{2, 4, 8};
    logic [8:0]  m;
    logic [1:0]  n;
    logic [13:0] cfg;
    int          t0;
    int          e;
    void'($urandom(32'hDBABB6C2));
    parQ.push_back({2'h0, 9'h0C8});
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    waitIdle();
    rd(`SDCL_REG_CONFIG, 1'b1, {18'h0, `SDCL_CFG_RESET});
    rd(8'h0C, 1'b1, 32'h0);
    $display("test reset done");
    foreach (bad[i]) begin
      wr(`SDCL_REG_CONFIG, {23'h0, bad[i]});
      rd(`SDCL_REG_STATUS, 1'b1, 32'h2);
      rd(`SDCL_REG_CONFIG, 1'b1, 32'hC8);
    end
    $display("test reject done");
    foreach (tc[i]) begin
      m = (i == 0) ? 9'h0C8 : 9'h190;
      n = 2'($urandom_range(0, 3));
      cfg = {tc[i], n, m};
      wr(`SDCL_REG_CONFIG, {18'h0, cfg});
      rd(`SDCL_REG_STATUS, 1'b1, 32'h0);
      serQ.push_back(cfg);
      wr(`SDCL_REG_CTRL, 32'h2);
      waitIdle();
      chk({31'h0, testOutput}, {31'h0, tc[i] == `SDCL_T_HIGH});
    end
    $display("test serial done");
    // top test bit of the last stream is 0, so the shifter output reads low
    parQ.push_back({n, m});
    wr(`SDCL_REG_CTRL, 32'h1);
    waitIdle();
    chk({31'h0, testOutput}, 32'h0);
    $display("test parallel done");
    foreach (nc[i]) begin
      m = 9'($urandom_range(200, 400));
      wr(`SDCL_REG_CONFIG, {21'h0, nc[i], m});
      parQ.push_back({nc[i], m});
      wr(`SDCL_REG_CTRL, 32'h1);
      waitIdle();
      repeat (128) @(posedge clk);
      t0 = toggles;
      repeat (1024) @(posedge clk);
      e = 16 * int'(m) / (4 * dv[i]);
      chk({31'h0, (toggles - t0 >= e - 3) && (toggles - t0 <= e + 3)}, 32'h1);
    end
    $display("test ratio done");
    stop_test();
  end
endmodule
`default_nettype wire
